// ==== core/lfwr_consts.vh ====
// lfwr_consts.vh: register offsets, field positions, reset values and timing counts
// for the low-frequency wake-up receiver control machine.
// assumes plain text inclusion by the apb-facing files; definitions only.
`ifndef LFWR_CONSTS_VH
`define LFWR_CONSTS_VH

// ==========================================================
// register byte offsets (one aligned 32-bit word each)
`define LFWR_OFF_CTRL 12'h000
`define LFWR_OFF_CFG 12'h004
`define LFWR_OFF_STATUS 12'h008
`define LFWR_OFF_MASK 12'h00C
`define LFWR_OFF_PAT 12'h010
`define LFWR_OFF_CDCNT 12'h014
`define LFWR_OFF_BUF0 12'h020
`define LFWR_OFF_ID 12'h03C

// ==========================================================
// control register fields
`define LFWR_CTRL_EN 0
`define LFWR_CTRL_TIM 1
`define LFWR_CTRL_INIT 2
// configuration register fields
`define LFWR_CFG_MODE_LO 0
`define LFWR_CFG_MODE_HI 1
`define LFWR_CFG_TWO_PAT 2
`define LFWR_CFG_PAT16 3
`define LFWR_CFG_BFADR_LO 4
`define LFWR_CFG_BFADR_HI 6
// status and mask flag positions
`define LFWR_FLG_CARRIER 0
`define LFWR_FLG_SYNC 1
`define LFWR_FLG_PATTERN 2
`define LFWR_FLG_BUFFULL 3
`define LFWR_FLG_EOM 4
`define LFWR_FLG_DECODE_ERROR_FLAG 5

// ==========================================================
// mode encodings
`define LFWR_MODE_CARRIER 2'b00
`define LFWR_MODE_DATA 2'b01
`define LFWR_MODE_TOGGLE 2'b10

// ==========================================================
// reset values and sizes
`define LFWR_CFG_RST 8'h00
`define LFWR_MASK_RST 6'h00
`define LFWR_CDCNT_RST 4'h1
`define LFWR_BUF_DEPTH 3'd7
// identity code, value arbitrary
`define LFWR_ID_VALUE 32'h00A5_5A01

// ==========================================================
// timing: pattern search timeout in half-bit strobes since the last decoded bit, for 8/16 bit patterns
`define LFWR_PAT_WIN8 6'd12
`define LFWR_PAT_WIN16 6'd20

`endif

// ==== core/lfwr_manch.v ====
// lfwr_manch.v: manchester half-bit decoder for the data slicer stream.
// assumes the slicer bit and the half-bit strobe are already synchronised to ref_clk.
`timescale 1ns/1ps

module lfwr_manch
(
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // half-bit sampled stream
   input wire half_stb,
   input wire half_bit,
   input wire clear,
   // decoded output
   output reg bit_valid,
   output reg bit_value,
   output reg code_viol
);

reg phase;
reg first_half;

// ==========================================================
// pair two halves: 10 is one, 01 is zero, equal halves break the code
always @(posedge ref_clk)
begin
   if (sys_rst || clear)
   begin
      phase <= 1'b0;
      first_half <= 1'b0;
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      code_viol <= 1'b0;
   end
   else
   begin
      bit_valid <= 1'b0;
      code_viol <= 1'b0;
      if (half_stb)
      begin
         if (!phase)
         begin
            first_half <= half_bit;
            phase <= 1'b1;
         end
         else
         begin
            phase <= 1'b0;
            if (first_half == half_bit)
               code_viol <= 1'b1;
            else
            begin
               bit_valid <= 1'b1;
               bit_value <= first_half;
            end
         end
      end
   end
end

endmodule // lfwr_manch

// ==== core/lfwr_fsm.v ====
// Functional notes
// - mode field picks carrier detect, data receive or toggle
// - enable off keeps receiver off; timer enable gates it to on phase
// - first setting of the enable bit initialises the machine
// - after some wake-ups machine waits for init; software sets reinit
// - reinit bit clears itself when the initialisation is done
// - with duty timer in use, off phase reinitialises automatically
// - every data mode wake-up clears the timer enable bit
// - carrier wake-up needs amplitude, duration and consecutive on periods
// - amplitude search, then duration timing with amplitude watched; fail restarts
// - on time ending in search or timing clears counter, back to idle
// - both met: count up; at threshold wake and wait init or off
// - below threshold receiver sleeps until on time ends
// - sync search stops at off; after sync stay active regardless
// - pattern search times out or aborts on violation; sync search restarts
// - valid pattern raises maskable wake-up then data reception continues
// - bytes go to a 7-byte ring; violation ends reception
// - unmasked end of message wakes, clears timer, waits init; masked restarts
// - buffer-full wake-up at chosen address, reception carries on
// - any code violation sets the decode error flag
// - toggle mode alternates data and carrier on successive on cycles
// - sync is mandatory; pattern, fill and violation are optional criteria
// - baseband logic runs on the slow oscillator clock
// - one or two patterns, each eight or sixteen bits
//
// lfwr_fsm.v: control machine of the wake-up receiver with its apb register file.
// assumes analog detector levels and slicer strobes arrive asynchronously on pins.
`timescale 1ns/1ps
`include "lfwr_consts.vh"

module lfwr_fsm
(
   // clock and reset (slow baseband clock)
   input wire ref_clk, // driven from the slow oscillator
   input wire sys_rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // front end and timer pins
   input wire amp_ok_pin,
   input wire dur_ok_pin,
   input wire half_stb_pin,
   input wire half_bit_pin,
   input wire timer_on_pin,
   // outputs
   output reg rx_active,
   output reg sens_data_sel,
   output reg wake_out
);

// ==========================================================
// states
localparam S_IDLE = 4'd0;
localparam S_AMP = 4'd1;
localparam S_DUR = 4'd2;
localparam S_CWAIT = 4'd3;
localparam S_SLEEP = 4'd4;
localparam S_SYNC = 4'd5;
localparam S_PAT = 4'd6;
localparam S_DATA = 4'd7;
localparam S_WINIT = 4'd8;

// fixed sync pattern as half-bit sequence, contains three code violations
localparam [11:0] SYNC_HALVES = 12'b1110_0011_1010;

reg [3:0] state;
reg rx_enable_bit;
reg duty_timer_enable;
reg reinit_request;
reg en_seen;
reg [7:0] rx_config_reg;
reg [5:0] flags;
reg [5:0] mask;
reg [15:0] pat0;
reg [15:0] pat1;
reg [3:0] carrier_count_threshold;
reg [3:0] carrier_hit_counter;
reg [7:0] rx_buf [0:6];
reg [2:0] wr_ptr;
reg [2:0] bit_cnt;
reg [7:0] shreg;
reg [15:0] pat_sh;
reg [4:0] pat_bits;
reg [5:0] pat_win;
reg [11:0] sync_sh;
reg toggle_data;
reg on_d;
reg [4:0] sync1;
reg [4:0] sync2;

wire amp_ok = sync2[0];
wire dur_ok = sync2[1];
wire half_stb_lvl = sync2[2];
wire half_bit = sync2[3];
wire timer_on = sync2[4];
reg stb_d;
wire half_stb = half_stb_lvl & ~stb_d;

wire [5:0] ev;
wire [1:0] mode = rx_config_reg[`LFWR_CFG_MODE_HI:`LFWR_CFG_MODE_LO];
wire pat16 = rx_config_reg[`LFWR_CFG_PAT16];
wire [2:0] bf_adr = rx_config_reg[`LFWR_CFG_BFADR_HI:`LFWR_CFG_BFADR_LO];
wire m_valid;
wire m_value;
wire m_viol;
wire wr_go = psel & penable & pwrite;

// ==========================================================
// activation: duty gate and its on/off edges
wire active_now = rx_enable_bit & (~duty_timer_enable | timer_on);
wire on_end = on_d & ~active_now;
wire on_start = ~on_d & active_now;
wire use_data = (mode == `LFWR_MODE_DATA) | ((mode == `LFWR_MODE_TOGGLE) & toggle_data);

// pattern match, one or two patterns, eight or sixteen bits
function pat_hit;
   input [15:0] sh;
   input [15:0] p;
   input wide;
   begin
      pat_hit = wide ? (sh == p) : (sh[7:0] == p[7:0]);
   end
endfunction

wire pat_done = (pat_bits == (pat16 ? 5'd16 : 5'd8));
wire pat_match = pat_hit(pat_sh, pat0, pat16)
   | (rx_config_reg[`LFWR_CFG_TWO_PAT] & pat_hit(pat_sh, pat1, pat16));
wire byte_done = m_valid & (bit_cnt == 3'd7) & (state == S_DATA);

// events decoded this cycle
assign ev[`LFWR_FLG_CARRIER] = (state == S_DUR) & amp_ok & dur_ok & active_now
   & (carrier_hit_counter + 4'd1 >= carrier_count_threshold);
assign ev[`LFWR_FLG_SYNC] = (state == S_SYNC) & active_now & half_stb
   & ({sync_sh[10:0], half_bit} == SYNC_HALVES);
assign ev[`LFWR_FLG_PATTERN] = (state == S_PAT) & pat_done & pat_match;
assign ev[`LFWR_FLG_BUFFULL] = byte_done & (wr_ptr == bf_adr);
assign ev[`LFWR_FLG_EOM] = (state == S_DATA) & m_viol;
assign ev[`LFWR_FLG_DECODE_ERROR_FLAG] = m_viol;

// ==========================================================
// manchester decoder, held clear outside pattern and data states
lfwr_manch u_manch
(
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .half_stb(half_stb),
   .half_bit(half_bit),
   .clear((state != S_PAT) && (state != S_DATA)),
   .bit_valid(m_valid),
   .bit_value(m_value),
   .code_viol(m_viol)
);

// ==========================================================
// two-stage pin synchroniser; only the second stage is read
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      stb_d <= 1'b0;
      on_d <= 1'b0;
   end
   else
   begin
      sync1 <= {timer_on_pin, half_bit_pin, half_stb_pin, dur_ok_pin, amp_ok_pin};
      sync2 <= sync1;
      stb_d <= half_stb_lvl;
      on_d <= active_now;
   end
end

// ==========================================================
// apb register writes, flags and control bits
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      rx_enable_bit <= 1'b0;
      duty_timer_enable <= 1'b0;
      reinit_request <= 1'b0;
      en_seen <= 1'b0;
      rx_config_reg <= `LFWR_CFG_RST;
      mask <= `LFWR_MASK_RST;
      pat0 <= 16'h0000;
      pat1 <= 16'h0000;
      carrier_count_threshold <= `LFWR_CDCNT_RST;
      flags <= 6'h00;
   end
   else
   begin
      if (wr_go && paddr == `LFWR_OFF_CTRL)
      begin
         rx_enable_bit <= pwdata[`LFWR_CTRL_EN];
         duty_timer_enable <= pwdata[`LFWR_CTRL_TIM];
         // first enable forces an init request
         reinit_request <= pwdata[`LFWR_CTRL_INIT] | (pwdata[`LFWR_CTRL_EN] & ~en_seen);
         if (pwdata[`LFWR_CTRL_EN])
            en_seen <= 1'b1;
      end
      else if (wr_go && paddr == `LFWR_OFF_CFG)
         rx_config_reg <= pwdata[7:0];
      else if (wr_go && paddr == `LFWR_OFF_MASK)
         mask <= pwdata[5:0];
      else if (wr_go && paddr == `LFWR_OFF_PAT)
      begin
         pat0 <= pwdata[15:0];
         pat1 <= pwdata[31:16];
      end
      else if (wr_go && paddr == `LFWR_OFF_CDCNT)
         carrier_count_threshold <= pwdata[3:0];
      // machine finished the requested init
      if (state == S_IDLE && reinit_request && !(wr_go && paddr == `LFWR_OFF_CTRL))
         reinit_request <= 1'b0;
      // data mode wake-ups drop the duty timer; hardware wins over a write
      if (ev[`LFWR_FLG_SYNC] | ev[`LFWR_FLG_PATTERN] | ev[`LFWR_FLG_BUFFULL]
          | (ev[`LFWR_FLG_EOM] & mask[`LFWR_FLG_EOM]))
         duty_timer_enable <= 1'b0;
      // write-one-to-clear; a simultaneous event keeps its flag set
      if (wr_go && paddr == `LFWR_OFF_STATUS)
         flags <= (flags & ~pwdata[5:0]) | ev;
      else
         flags <= flags | ev;
   end
end

// ==========================================================
// main control machine
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      state <= S_IDLE;
      carrier_hit_counter <= 4'h0;
      toggle_data <= 1'b0;
      sync_sh <= 12'h000;
      pat_sh <= 16'h0000;
      pat_bits <= 5'd0;
      pat_win <= 6'd0;
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
      wr_ptr <= 3'd0;
   end
   else
   begin
      case (state)
      S_IDLE:
      begin
         if (on_start)
         begin
            // toggle_data then names the branch taken, so the sensitivity output follows it
            toggle_data <= ~toggle_data;
            if ((mode == `LFWR_MODE_DATA) || ((mode == `LFWR_MODE_TOGGLE) && !toggle_data))
            begin
               state <= S_SYNC;
               sync_sh <= 12'h000;
            end
            else
               state <= S_AMP;
         end
      end
      S_AMP:
      begin
         if (on_end)
         begin
            carrier_hit_counter <= 4'h0;
            state <= S_IDLE;
         end
         else if (amp_ok)
            state <= S_DUR;
      end
      S_DUR:
      begin
         if (on_end)
         begin
            carrier_hit_counter <= 4'h0;
            state <= S_IDLE;
         end
         else if (!amp_ok)
            state <= S_AMP;
         else if (dur_ok)
         begin
            carrier_hit_counter <= carrier_hit_counter + 4'd1;
            if (ev[`LFWR_FLG_CARRIER])
               state <= S_CWAIT;
            else
               state <= S_SLEEP;
         end
      end
      S_CWAIT:
      begin
         // leave on reinit or on time ending
         if (reinit_request || on_end || !active_now)
         begin
            carrier_hit_counter <= 4'h0;
            state <= S_IDLE;
         end
      end
      S_SLEEP:
      begin
         if (!active_now)
            state <= S_IDLE;
      end
      S_SYNC:
      begin
         if (!active_now)
            state <= S_IDLE;
         else if (half_stb)
         begin
            sync_sh <= {sync_sh[10:0], half_bit};
            if (ev[`LFWR_FLG_SYNC])
            begin
               // sync alone is enough to proceed
               state <= S_PAT;
               pat_bits <= 5'd0;
               pat_win <= 6'd0;
            end
         end
      end
      S_PAT:
      begin
         if (m_viol || pat_win == (pat16 ? `LFWR_PAT_WIN16 : `LFWR_PAT_WIN8))
         begin
            state <= S_SYNC;
            sync_sh <= 12'h000;
         end
         else if (pat_done)
         begin
            if (pat_match && rx_enable_bit)
            begin
               state <= S_DATA;
               bit_cnt <= 3'd0;
            end
            else if (pat_match)
               state <= S_WINIT;
            else
            begin
               state <= S_SYNC;
               sync_sh <= 12'h000;
            end
         end
         else
         begin
            // window restarts at each decoded bit; the bit pulse trails its strobe
            if (m_valid)
            begin
               pat_sh <= {pat_sh[14:0], m_value};
               pat_bits <= pat_bits + 5'd1;
               pat_win <= 6'd0;
            end
            else if (half_stb)
               pat_win <= pat_win + 6'd1;
         end
      end
      S_DATA:
      begin
         if (m_viol)
         begin
            if (mask[`LFWR_FLG_EOM] || !active_now)
               state <= S_WINIT;
            else
            begin
               state <= S_SYNC;
               sync_sh <= 12'h000;
            end
         end
         else if (m_valid)
         begin
            shreg <= {shreg[6:0], m_value};
            bit_cnt <= bit_cnt + 3'd1;
            if (byte_done)
               // ring wrap; reception continues past a buffer-full wake
               wr_ptr <= (wr_ptr == `LFWR_BUF_DEPTH - 3'd1) ? 3'd0 : wr_ptr + 3'd1;
         end
      end
      S_WINIT:
      begin
         // off phase of the duty timer also reinitialises
         if (reinit_request || (duty_timer_enable && !timer_on))
            state <= S_IDLE;
      end
      default:
         state <= S_IDLE;
      endcase
   end
end

// ==========================================================
// ring buffer storage, no reset needed for data
always @(posedge ref_clk)
begin
   if (byte_done)
      rx_buf[wr_ptr] <= {shreg[6:0], m_value};
end

// ==========================================================
// apb answer: zero wait states, unmapped reads zero with error
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end
   else
   begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
         if (paddr == `LFWR_OFF_CTRL)
            prdata <= {29'h0, reinit_request, duty_timer_enable, rx_enable_bit};
         else if (paddr == `LFWR_OFF_CFG)
            prdata <= {24'h0, rx_config_reg};
         else if (paddr == `LFWR_OFF_STATUS)
            prdata <= {22'h0, state, flags};
         else if (paddr == `LFWR_OFF_MASK)
            prdata <= {26'h0, mask};
         else if (paddr == `LFWR_OFF_PAT)
            prdata <= {pat1, pat0};
         else if (paddr == `LFWR_OFF_CDCNT)
            prdata <= {24'h0, carrier_hit_counter, carrier_count_threshold};
         else if (paddr >= `LFWR_OFF_BUF0 && paddr < `LFWR_OFF_BUF0 + 12'h01C && paddr[1:0] == 2'b00)
            prdata <= {24'h0, rx_buf[paddr[4:2]]};
         else if (paddr == `LFWR_OFF_ID)
            prdata <= `LFWR_ID_VALUE;
         else
            pslverr <= 1'b1;
      end
   end
end

// ==========================================================
// registered outputs
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      rx_active <= 1'b0;
      sens_data_sel <= 1'b0;
      wake_out <= 1'b0;
   end
   else
   begin
      rx_active <= (state != S_IDLE) && (state != S_SLEEP) && (state != S_WINIT);
      sens_data_sel <= use_data;
      wake_out <= |(flags & mask & 6'h1F);
   end
end

endmodule // lfwr_fsm

// ==== verif/lfwr_fsm_asserts.sv ====
// port checker for the wake-up receiver control machine
// assumes a bind onto lfwr_fsm, one clock, synchronous reset
`timescale 1ns/1ps
`include "lfwr_consts.vh"

module lfwr_fsm_chk
(
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // timer and outputs
   input wire timer_on_pin,
   input wire rx_active,
   input wire sens_data_sel,
   input wire wake_out
);
   logic en_q;
   logic tim_q;
   logic [1:0] mode_q;
   logic [5:0] mask_q;

   // ==========
   // shadow of settings
   // the device clears the timer bit itself in data mode, so tim_q is used in carrier mode only
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         en_q <= 1'b0;
         tim_q <= 1'b0;
         mode_q <= `LFWR_MODE_CARRIER;
         mask_q <= `LFWR_MASK_RST;
      end
      else if (psel && penable && pready && pwrite)
      begin
         case (paddr)
            `LFWR_OFF_CTRL:
            begin
               en_q <= pwdata[`LFWR_CTRL_EN];
               tim_q <= pwdata[`LFWR_CTRL_TIM];
            end
            `LFWR_OFF_CFG: mode_q <= pwdata[1:0];
            `LFWR_OFF_MASK: mask_q <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // ==========
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_duty_off;
      (mode_q == `LFWR_MODE_CARRIER && en_q && tim_q && !timer_on_pin) [*6];
   endsequence
   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_unmapped;
      s_setup ##0 (paddr >= 12'h040) |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   property p_mapped;
      s_setup ##0 (paddr < 12'h018) && (paddr[1:0] == 2'b00) |=> !pslverr;
   endproperty
   property p_off;
      (!en_q) [*4] |-> !rx_active;
   endproperty
   property p_duty;
      s_duty_off |-> !rx_active;
   endproperty
   property p_mask;
      (mask_q == 6'h00) [*3] |-> !wake_out;
   endproperty
   property p_sens;
      (mode_q == `LFWR_MODE_DATA) [*4] |-> sens_data_sel;
   endproperty

   a_answer: assert property (p_answer)
      else $error("apb access without ready");
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   a_mapped: assert property (p_mapped)
      else $error("mapped access refused");
   a_off: assert property (p_off)
      else $error("receiver active while disabled");
   a_duty: assert property (p_duty)
      else $error("carrier receiver active in off phase");
   a_mask: assert property (p_mask)
      else $error("wake output with all events masked");
   a_sens: assert property (p_sens)
      else $error("carrier sensitivity in data mode");
endmodule // lfwr_fsm_chk

// ==== verif/lfwr_base_stn.sv ====
// behavioural lf base station driving detector and slicer pins
// assumes every pin is synchronised on ref_clk inside the receiver
`timescale 1ns/1ps

module lfwr_base_stn
(
   // clock
   input wire ref_clk,
   // detector and slicer pins
   output logic amp_ok,
   output logic dur_ok,
   output logic half_stb,
   output logic half_bit
);
   logic busy;

   // ==========
   // idle lines
   initial
   begin
      busy = 1'b0;
      amp_ok = 1'b0;
      dur_ok = 1'b0;
      half_stb = 1'b0;
      half_bit = 1'b0;
   end

   // slicer level means nothing between frames: keep it moving so no stale value helps
   always @(posedge ref_clk)
   begin
      if (!busy)
         half_bit <= ~half_bit;
   end

   // ==========
   // telegram pieces
   // level settles 2 cycles before the strobe and holds 3 after it
   task half(input logic b);
      half_bit <= b;
      repeat (2) @(posedge ref_clk);
      half_stb <= 1'b1;
      repeat (3) @(posedge ref_clk);
      half_stb <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   // manchester byte, msb first, one as high then low
   task mbyte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
      begin
         half(v[i]);
         half(~v[i]);
      end
   endtask

   // sync, wake pattern, data, then a violation to end the message
   task frame(input logic [7:0] pat, input int nb, input logic [7:0] base);
      busy <= 1'b1;
      @(posedge ref_clk);
      for (int i = 11; i >= 0; i--)
         half(12'hE3A >> i);
      mbyte(pat);
      for (int k = 0; k < nb; k++)
         mbyte(base + 8'(k));
      half(1'b1);
      half(1'b1);
      busy <= 1'b0;
   endtask

   // carrier burst: amplitude first, duration qualifies later
   task carrier;
      amp_ok <= 1'b1;
      repeat (6) @(posedge ref_clk);
      dur_ok <= 1'b1;
      repeat (6) @(posedge ref_clk);
      amp_ok <= 1'b0;
      dur_ok <= 1'b0;
   endtask
endmodule // lfwr_base_stn

// ==== verif/tb_lf_wakeup_receiver_fsm.sv ====
// self-checking bench for the wake-up receiver control machine
// assumes lfwr_fsm, the base station model and the checker compiled first
`timescale 1ns/1ps
`include "lfwr_consts.vh"

module tb_lf_wakeup_receiver_fsm;
   logic ref_clk, sys_rst, psel, penable, pwrite, timer_on, pready, pslverr, e;
   logic amp, dur, stb, hb, rx_active, sens, wake_out, prev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int n_fail = 0;
   int n_tests = 0;

   lfwr_fsm DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .amp_ok_pin(amp), .dur_ok_pin(dur), .half_stb_pin(stb),
      .half_bit_pin(hb), .timer_on_pin(timer_on), .rx_active(rx_active),
      .sens_data_sel(sens), .wake_out(wake_out));
   lfwr_base_stn BS (.ref_clk(ref_clk), .amp_ok(amp), .dur_ok(dur), .half_stb(stb),
      .half_bit(hb));

   // ==========
   // clock and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // the whole run needs about 1700 cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end

   // ==========
   // tasks
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask

   // one apb transfer, entered just after an edge; idle cycle after it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for ready
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, q & m, x);
   endtask

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // off phase then a fresh on phase
   task new_on;
      timer_on <= 1'b0;
      tick(10);
      timer_on <= 1'b1;
      tick(10);
   endtask

   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========
   // tests
   initial
   begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, timer_on} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      tick(5);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rdc("id", `LFWR_OFF_ID, 32'hFFFF_FFFF, `LFWR_ID_VALUE);
      rdc("cfg", `LFWR_OFF_CFG, 32'h0000_00FF, 32'h0000_0000);
      rdc("mask", `LFWR_OFF_MASK, 32'h0000_003F, 32'h0000_0000);
      rdc("cdcnt", `LFWR_OFF_CDCNT, 32'h0000_000F, 32'h0000_0001);
      apb(1'b1, 12'h040, 32'hFFFF_FFFF);
      chk("err_wr", e, 1'b1);
      rdc("err_rd", 12'h040, 32'hFFFF_FFFF, 32'h0000_0000);
      chk("err_rd", e, 1'b1);
      apb(1'b1, `LFWR_OFF_PAT, 32'h1234_00A5);
      rdc("pat", `LFWR_OFF_PAT, 32'hFFFF_FFFF, 32'h1234_00A5);
      chk("rx_off", rx_active, 1'b0);
      apb(1'b1, `LFWR_OFF_CTRL, 32'h0000_0001);
      tick(10);
      chk("rx_always", rx_active, 1'b1);
      apb(1'b1, `LFWR_OFF_CTRL, 32'h0000_0003);
      tick(10);
      chk("rx_offph", rx_active, 1'b0);
      timer_on <= 1'b1;
      tick(10);
      chk("rx_onph", rx_active, 1'b1);
      // toggle mode: each on phase flips the sensitivity
      apb(1'b1, `LFWR_OFF_CFG, 32'h0000_0002);
      for (int i = 0; i < 4; i++)
      begin
         new_on;
         if (i > 0)
            chk("toggle", sens ^ prev, 1'b1);
         prev = sens;
      end
      // carrier mode, two consecutive hits needed
      apb(1'b1, `LFWR_OFF_CFG, 32'h0000_0000);
      apb(1'b1, `LFWR_OFF_CDCNT, 32'h0000_0002);
      apb(1'b1, `LFWR_OFF_MASK, 32'h0000_0001);
      apb(1'b1, `LFWR_OFF_CTRL, 32'h0000_0003);
      new_on;
      BS.carrier();
      tick(6);
      chk("rx_hit", rx_active, 1'b0);
      rdc("cw1", `LFWR_OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      new_on;
      new_on;
      BS.carrier();
      tick(6);
      rdc("cw2", `LFWR_OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      new_on;
      BS.carrier();
      tick(6);
      rdc("cw3", `LFWR_OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
      chk("wake", wake_out, 1'b1);
      apb(1'b1, `LFWR_OFF_STATUS, 32'h0000_0001);
      tick(4);
      chk("wake_clr", wake_out, 1'b0);
      // data mode, off phase arrives during pattern search
      apb(1'b1, `LFWR_OFF_CFG, 32'h0000_0011);
      apb(1'b1, `LFWR_OFF_PAT, 32'h0000_00A5);
      apb(1'b1, `LFWR_OFF_MASK, 32'h0000_001E);
      apb(1'b1, `LFWR_OFF_CTRL, 32'h0000_0003);
      new_on;
      fork
         BS.frame(8'hA5, 8, 8'h40);
         begin
            tick(150);
            timer_on <= 1'b0;
         end
      join
      tick(20);
      rdc("flags", `LFWR_OFF_STATUS, 32'h0000_003F, 32'h0000_003E);
      chk("wake_eom", wake_out, 1'b1);
      rdc("tim_bit", `LFWR_OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
      for (int i = 0; i < 7; i++)
         rdc("buf", 12'(`LFWR_OFF_BUF0 + 4 * i), 32'h0000_00FF, 32'((i == 0) ? 8'h47 : 8'h40 + i));
      apb(1'b1, `LFWR_OFF_CTRL, 32'h0000_0005);
      tick(20);
      rdc("reinit", `LFWR_OFF_CTRL, 32'h0000_0004, 32'h0000_0000);
      conclude();
   end
endmodule // tb_lf_wakeup_receiver_fsm

bind lfwr_fsm lfwr_fsm_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_on_pin(timer_on_pin), .rx_active(rx_active),
   .sens_data_sel(sens_data_sel), .wake_out(wake_out));
